// file: design/srctl_regs.vh
`ifndef SRCTL_REGS_VH
`define SRCTL_REGS_VH
// Register byte offsets
`define SRCTL_OFS_CAUSE      8'h00
`define SRCTL_OFS_BROWNOUT   8'h04
`define SRCTL_OFS_PRST0      8'h08
`define SRCTL_OFS_PRST1      8'h0c
`define SRCTL_OFS_PRST2      8'h10
`define SRCTL_OFS_APPINT     8'h14
`define SRCTL_OFS_STATUS     8'h18
// Cause register fields
`define SRCTL_CAUSE_EXT      0
`define SRCTL_CAUSE_POR      1
`define SRCTL_CAUSE_BOR      2
`define SRCTL_CAUSE_WDT      3
`define SRCTL_CAUSE_SW       4
`define SRCTL_CAUSE_W        5
// Brown-out control fields
`define SRCTL_BO_RESET_EN    1
`define SRCTL_BO_INT_CLR     0
// App interrupt/reset control field
`define SRCTL_APPINT_SYSREQ  2
// Reset values
`define SRCTL_BROWNOUT_RST   2'h0
`define SRCTL_PRST_RST       32'h00000000
// Timing: internal reset hold and clock period
`define SRCTL_RST_HOLD_NS    160
`define SRCTL_CLK_NS         40
`define SRCTL_RST_HOLD_CYC   ((`SRCTL_RST_HOLD_NS + `SRCTL_CLK_NS - 1) / `SRCTL_CLK_NS)
// AXI responses
`define SRCTL_RESP_OKAY      2'h0
`define SRCTL_RESP_SLVERR    2'h2
`endif

// file: design/srctl_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser; resets to the asserted (low) level of an active-low pin
module srctl_sync (
    input  wire i_clock,
    input  wire i_sys_rst,
    input  wire i_async,
    output wire o_sync
);
    reg stage1_reg;
    reg stage2_reg;

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
        end
    end

    assign o_sync = stage2_reg;
endmodule // srctl_sync

// file: design/srctl_boot.v
`timescale 1ns/1ps
`include "srctl_regs.vh"
// Boot fetch sequencer: stack pointer, program counter, first instruction, run
module srctl_boot (
    input  wire       i_clock,
    input  wire       i_sys_rst,
    input  wire       i_core_rst,
    input  wire       i_fetch_ack,
    output reg  [1:0] o_fetch_kind,
    output reg        o_fetch_req,
    output reg        o_running
);
    localparam [3:0] ST_SP   = 4'b0001;
    localparam [3:0] ST_PC   = 4'b0010;
    localparam [3:0] ST_INST = 4'b0100;
    localparam [3:0] ST_RUN  = 4'b1000;

    reg [3:0] state_reg;
    reg [3:0] state_next;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_SP:   if (i_fetch_ack) state_next = ST_PC;
            ST_PC:   if (i_fetch_ack) state_next = ST_INST;
            ST_INST: if (i_fetch_ack) state_next = ST_RUN;
            ST_RUN:  state_next = ST_RUN;
            default: state_next = ST_SP;
        endcase
    end

    always @(posedge i_clock) begin
        if (i_sys_rst || i_core_rst) begin
            state_reg    <= ST_SP;
            o_fetch_req  <= 1'b0;
            o_fetch_kind <= 2'h0;
            o_running    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            o_fetch_req  <= (state_next != ST_RUN);
            o_fetch_kind <= state_next[1] ? 2'h1 : (state_next[2] ? 2'h2 : 2'h0);
            o_running    <= (state_next == ST_RUN);
        end
    end
endmodule // srctl_boot

// file: design/srctl_top.v
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "srctl_regs.vh"
// Summary of operation
// - Five sources: pin, power-on, brown-out, software, watchdog
// - Power-on resets core, peripherals and debug port
// - Reset pin resets core, peripherals, not debug
// - Brown-out acts like pin, held while supply bad
// - Brown-out reset disabled after reset, software enables
// - Brown-out raises interrupt when reset disabled, resets when enabled
// - Peripheral reset on set-then-clear of its bit
// - Peripheral bits follow clock-gating bit layout
// - Peripheral reset hits every clock domain of unit
// - System request resets all except debug port
// - Request write, internal reset asserted, then released
// - Cause flag set for the resetting source
// - Cause flags sticky and accumulate across resets
// - Power-on or pin cause clears other flags
// - After release fetch stack, counter, instruction, run
// - Power-on holds reset until detector goes inactive
// - Power-on detector fires only at first power-up
// - Watchdog second timeout resets when reset enabled
module srctl_top #(
    parameter NPER = 32
) (
    input  wire             i_clock,
    input  wire             i_sys_rst,
    input  wire             i_ext_rst_n,
    input  wire             i_por_active,
    input  wire             i_supply_bad,
    input  wire             i_wdt_second_timeout,
    input  wire             i_wdt_reset_en,
    input  wire             i_test_mode_pin_0,
    input  wire             i_test_mode_pin_1,
    input  wire             i_fetch_ack,
    input  wire [7:0]       i_awaddr,
    input  wire             i_awvalid,
    output reg              o_awready,
    input  wire [31:0]      i_wdata,
    input  wire [3:0]       i_wstrb,
    input  wire             i_wvalid,
    output reg              o_wready,
    output reg  [1:0]       o_bresp,
    output reg              o_bvalid,
    input  wire             i_bready,
    input  wire [7:0]       i_araddr,
    input  wire             i_arvalid,
    output reg              o_arready,
    output reg  [31:0]      o_rdata,
    output reg  [1:0]       o_rresp,
    output reg              o_rvalid,
    input  wire             i_rready,
    output reg              o_core_rst,
    output reg              o_debug_rst,
    output reg  [3*NPER-1:0] o_periph_rst,
    output reg              o_brownout_irq,
    output wire [1:0]       o_fetch_kind,
    output wire             o_fetch_req,
    output wire             o_running
);
    localparam integer HOLD = `SRCTL_RST_HOLD_CYC, PRST_RST = `SRCTL_PRST_RST;

    // ------------------------------------------------------------
    // Source conditioning
    // ------------------------------------------------------------
    wire ext_n_sync;
    srctl_sync u_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_ext_rst_n),
        .o_sync    (ext_n_sync)
    );

    reg        por_seen_reg;
    reg        bo_prev_reg;
    reg  [1:0] brownout_control_reg;
    reg  [3*NPER-1:0] peripheral_reset_regs;
    reg  [3*NPER-1:0] prst_prev_reg;
    reg  [`SRCTL_CAUSE_W-1:0] reset_cause_reg;
    reg        sysreq_reg;
    reg  [7:0] hold_cnt_reg;
    reg        in_reset_reg;

    // Power-on counts only until the detector first drops; later pulses ignored
    wire por_src  = i_por_active && !por_seen_reg;
    wire ext_src  = !ext_n_sync;
    wire bor_src  = i_supply_bad &&
                    brownout_control_reg[`SRCTL_BO_RESET_EN];
    wire wdt_src  = i_wdt_second_timeout && i_wdt_reset_en;
    wire sw_src   = sysreq_reg;
    wire any_src  = por_src | ext_src | bor_src | wdt_src | sw_src;
    wire core_rst_next = any_src || in_reset_reg;

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            por_seen_reg <= 1'b0;
        end else if (!i_por_active) begin
            por_seen_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Internal reset sequencing
    // ------------------------------------------------------------
    // Level sources keep the counter reloaded, so release follows the source
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            hold_cnt_reg <= HOLD[7:0];
            in_reset_reg <= 1'b1;
            o_core_rst   <= 1'b1;
            o_debug_rst  <= 1'b1;
        end else begin
            if (any_src) begin
                hold_cnt_reg <= HOLD[7:0];
                in_reset_reg <= 1'b1;
            end else if (hold_cnt_reg != 8'h00) begin
                hold_cnt_reg <= hold_cnt_reg - 8'h01;
            end else begin
                in_reset_reg <= 1'b0;
            end
            o_core_rst  <= core_rst_next;
            o_debug_rst <= por_src;
        end
    end

    // ------------------------------------------------------------
    // Peripheral resets: set-then-clear pulses; also every system reset
    // ------------------------------------------------------------
    // Bit n of each word lines up with bit n of the clock-gating words
    genvar g;
    generate
        for (g = 0; g < 3*NPER; g = g + 1) begin : g_prst
            always @(posedge i_clock) begin
                if (i_sys_rst) begin
                    o_periph_rst[g] <= 1'b1;
                end else begin
                    o_periph_rst[g] <= (prst_prev_reg[g] && !peripheral_reset_regs[g])
                                       || core_rst_next;
                end
            end
        end
    endgenerate

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            prst_prev_reg <= {3*NPER{1'b0}};
            bo_prev_reg   <= 1'b0;
        end else begin
            prst_prev_reg <= peripheral_reset_regs;
            bo_prev_reg   <= i_supply_bad;
        end
    end

    // ------------------------------------------------------------
    // Cause flags: cleared by i_sys_rst, by a zero written to the bit, and by a power-on or pin source
    // ------------------------------------------------------------
    reg [`SRCTL_CAUSE_W-1:0] cause_clr;
    reg [`SRCTL_CAUSE_W-1:0] cause_set;
    always @* begin
        cause_set = {`SRCTL_CAUSE_W{1'b0}};
        cause_set[`SRCTL_CAUSE_EXT] = ext_src;
        cause_set[`SRCTL_CAUSE_POR] = por_src;
        cause_set[`SRCTL_CAUSE_BOR] = bor_src;
        cause_set[`SRCTL_CAUSE_WDT] = wdt_src;
        cause_set[`SRCTL_CAUSE_SW]  = sw_src;
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave: write takes address and data in either order
    // ------------------------------------------------------------
    reg        aw_held_reg;
    reg        w_held_reg;
    reg  [7:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg  [3:0] wstrb_reg;
    wire       wr_go = aw_held_reg && w_held_reg && !o_bvalid;
    wire       wr_cause = wr_go && awaddr_reg == `SRCTL_OFS_CAUSE && wstrb_reg[0];
    wire       wr_bo    = wr_go && awaddr_reg == `SRCTL_OFS_BROWNOUT && wstrb_reg[0];
    wire       wr_app   = wr_go && awaddr_reg == `SRCTL_OFS_APPINT && wstrb_reg[0];
    wire       wr_map   = awaddr_reg == `SRCTL_OFS_CAUSE || awaddr_reg == `SRCTL_OFS_BROWNOUT ||
                          awaddr_reg == `SRCTL_OFS_PRST0 || awaddr_reg == `SRCTL_OFS_PRST1 ||
                          awaddr_reg == `SRCTL_OFS_PRST2 || awaddr_reg == `SRCTL_OFS_APPINT;

    always @* begin
        cause_clr = {`SRCTL_CAUSE_W{1'b0}};
        if (wr_cause)
            cause_clr = ~wdata_reg[`SRCTL_CAUSE_W-1:0];
    end

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            reset_cause_reg <= {`SRCTL_CAUSE_W{1'b0}};
        end else if (por_src || ext_src) begin
            reset_cause_reg <= {`SRCTL_CAUSE_W{1'b0}};
            reset_cause_reg[`SRCTL_CAUSE_EXT] <= ext_src;
            reset_cause_reg[`SRCTL_CAUSE_POR] <= por_src;
        end else begin
            reset_cause_reg <= (reset_cause_reg & ~cause_clr) | cause_set;
        end
    end

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            o_awready   <= 1'b1;
            o_wready    <= 1'b1;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
            o_bvalid    <= 1'b0;
            o_bresp     <= `SRCTL_RESP_OKAY;
            brownout_control_reg  <= `SRCTL_BROWNOUT_RST;
            peripheral_reset_regs <= {3{PRST_RST[NPER-1:0]}};
            sysreq_reg     <= 1'b0;
            o_brownout_irq <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= i_awaddr;
                o_awready   <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= i_wdata;
                wstrb_reg  <= i_wstrb;
                o_wready   <= 1'b0;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                o_bvalid    <= 1'b1;
                o_bresp     <= wr_map ? `SRCTL_RESP_OKAY : `SRCTL_RESP_SLVERR;
                case (awaddr_reg)
                    `SRCTL_OFS_PRST0: peripheral_reset_regs[NPER-1:0] <= wdata_reg[NPER-1:0];
                    `SRCTL_OFS_PRST1: peripheral_reset_regs[2*NPER-1:NPER] <= wdata_reg[NPER-1:0];
                    `SRCTL_OFS_PRST2: peripheral_reset_regs[3*NPER-1:2*NPER] <= wdata_reg[NPER-1:0];
                    default: ;
                endcase
            end
            if (wr_bo)
                brownout_control_reg[`SRCTL_BO_RESET_EN] <= wdata_reg[`SRCTL_BO_RESET_EN];
            if (o_bvalid && i_bready) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
            // Request self-clears once the internal reset has taken hold
            if (wr_app && wdata_reg[`SRCTL_APPINT_SYSREQ])
                sysreq_reg <= 1'b1;
            else if (sysreq_reg)
                sysreq_reg <= 1'b0;
            // Interrupt set on a new brown-out wins over the clear write
            if (i_supply_bad && !bo_prev_reg && !brownout_control_reg[`SRCTL_BO_RESET_EN])
                o_brownout_irq <= 1'b1;
            else if (wr_bo && wdata_reg[`SRCTL_BO_INT_CLR])
                o_brownout_irq <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `SRCTL_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= `SRCTL_RESP_OKAY;
            o_rdata   <= 32'h00000000;
            case (i_araddr)
                `SRCTL_OFS_CAUSE:    o_rdata[`SRCTL_CAUSE_W-1:0] <= reset_cause_reg;
                `SRCTL_OFS_BROWNOUT: o_rdata[1:0] <= {brownout_control_reg[1], o_brownout_irq};
                `SRCTL_OFS_PRST0:    o_rdata[NPER-1:0] <= peripheral_reset_regs[NPER-1:0];
                `SRCTL_OFS_PRST1:    o_rdata[NPER-1:0] <= peripheral_reset_regs[2*NPER-1:NPER];
                `SRCTL_OFS_PRST2:    o_rdata[NPER-1:0] <= peripheral_reset_regs[3*NPER-1:2*NPER];
                `SRCTL_OFS_APPINT:   o_rdata <= 32'h00000000;
                `SRCTL_OFS_STATUS:   o_rdata[3:0] <= {i_test_mode_pin_1, i_test_mode_pin_0,
                                                      o_running, in_reset_reg};
                default:             o_rresp <= `SRCTL_RESP_SLVERR;
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Boot fetch after internal reset release
    // ------------------------------------------------------------
    srctl_boot u_boot (
        .i_clock      (i_clock),
        .i_sys_rst    (i_sys_rst),
        .i_core_rst   (core_rst_next),
        .i_fetch_ack  (i_fetch_ack),
        .o_fetch_kind (o_fetch_kind),
        .o_fetch_req  (o_fetch_req),
        .o_running    (o_running)
    );
endmodule // srctl_top

// file: sim/srctl_fetch_model.sv
`timescale 1ns/1ps
// ------------------------------------
// Boot memory and board straps
// ------------------------------------
module srctl_fetch_model (
    input  wire i_clock,
    input  wire i_slow,
    input  wire i_fetch_req,
    output reg  o_fetch_ack,
    output wire o_test_mode_pin_0,
    output wire o_test_mode_pin_1
);
    integer wait_cnt = 0;
    assign o_test_mode_pin_0 = 1'b0;
    assign o_test_mode_pin_1 = 1'b0;
    initial o_fetch_ack = 1'b0;
    // Single-cycle ack, then a gap so the next fetch is seen fresh
    always @(posedge i_clock) begin
        if (o_fetch_ack || i_fetch_req !== 1'b1) begin
            o_fetch_ack <= 1'b0;
            wait_cnt    <= 0;
        end else if (wait_cnt >= (i_slow ? 3 : 0)) begin
            o_fetch_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule // srctl_fetch_model

// file: sim/srctl_checker.sv
`timescale 1ns/1ps
module srctl_checker #(
    parameter NPER = 32
) (
    input wire              i_clock,
    input wire              i_sys_rst,
    input wire              i_ext_rst_n,
    input wire              i_por_active,
    input wire              i_wdt_second_timeout,
    input wire              i_wdt_reset_en,
    input wire              i_fetch_ack,
    input wire              i_bready,
    input wire              i_rready,
    input wire              o_bvalid,
    input wire              o_rvalid,
    input wire [31:0]       o_rdata,
    input wire              o_core_rst,
    input wire              o_debug_rst,
    input wire [3*NPER-1:0] o_periph_rst,
    input wire [1:0]        o_fetch_kind,
    input wire              o_fetch_req,
    input wire              o_running
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------
    // Reset fan-out and boot order
    // ------------------------------------
    sequence s_ack(logic [1:0] k);
        o_fetch_req && i_fetch_ack && o_fetch_kind == k && !o_core_rst;
    endsequence
    a_pin_reset: assert property (!i_ext_rst_n |-> ##[1:4] o_core_rst)
        else $error("pin low did not reset core");
    // Pin must be seen high through the synchroniser and the hold count
    a_pin_release: assert property ($fell(o_core_rst) |-> $past(i_ext_rst_n, 4))
        else $error("core released too soon after pin");
    a_wdt_reset: assert property (i_wdt_second_timeout && i_wdt_reset_en |=> o_core_rst)
        else $error("watchdog did not reset core");
    a_debug_core: assert property (o_debug_rst |-> o_core_rst)
        else $error("debug reset without core reset");
    a_debug_pin: assert property (!i_por_active && !$past(i_por_active) && !o_debug_rst
        |=> !o_debug_rst) else $error("debug reset outside power-on");
    a_periph_core: assert property (o_core_rst |-> &o_periph_rst)
        else $error("peripheral not reset with core");
    a_periph_pulse: assert property (|o_periph_rst && !o_core_rst
        |=> (o_periph_rst == '0 || o_core_rst)) else $error("peripheral pulse too long");
    a_boot_start: assert property ($fell(o_core_rst) |-> ##[0:1] (o_fetch_req
        && o_fetch_kind == 2'h0)) else $error("boot did not start with stack fetch");
    a_boot_pc: assert property (s_ack(2'h0) |-> ##[1:2] (o_fetch_kind == 2'h1))
        else $error("counter fetch missing");
    a_boot_ins: assert property (s_ack(2'h1) |-> ##[1:2] (o_fetch_kind == 2'h2))
        else $error("instruction fetch missing");
    a_boot_run: assert property (s_ack(2'h2) |-> ##[1:2] o_running)
        else $error("core did not start");
    a_core_idle: assert property (o_core_rst |-> !o_running)
        else $error("running during reset");
    a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read response changed");
endmodule // srctl_checker
bind srctl_top srctl_checker #(.NPER(NPER)) u_chk (.i_clock, .i_sys_rst, .i_ext_rst_n,
    .i_por_active, .i_wdt_second_timeout, .i_wdt_reset_en, .i_fetch_ack, .i_bready,
    .i_rready, .o_bvalid, .o_rvalid, .o_rdata, .o_core_rst, .o_debug_rst, .o_periph_rst,
    .o_fetch_kind, .o_fetch_req, .o_running);

// file: sim/tb.sv
`timescale 1ns/1ps
`include "srctl_regs.vh"
module tb;
    localparam NPER = 32;
    reg               i_clock = 1'b0;
    reg               i_sys_rst = 1'b1;
    reg               i_ext_rst_n = 1'b1;
    reg               i_por_active = 1'b0;
    reg               i_supply_bad = 1'b0;
    reg               i_wdt_second_timeout = 1'b0;
    reg               i_wdt_reset_en = 1'b0;
    reg               slow = 1'b0;
    reg  [7:0]        i_awaddr = 8'h00, i_araddr = 8'h00;
    reg  [31:0]       i_wdata = 32'h0;
    reg  [3:0]        i_wstrb = 4'hf;
    reg               i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    reg               i_arvalid = 1'b0, i_rready = 1'b0;
    wire              i_fetch_ack, i_test_mode_pin_0, i_test_mode_pin_1;
    wire              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire [1:0]        o_bresp, o_rresp, o_fetch_kind;
    wire [31:0]       o_rdata;
    wire              o_core_rst, o_debug_rst, o_brownout_irq, o_fetch_req, o_running;
    wire [3*NPER-1:0] o_periph_rst;
    reg  [31:0]       seed = 32'h2c874962;
    reg  [31:0]       rd_data;
    reg  [1:0]        rd_resp, wr_resp;
    reg  [3*NPER-1:0] acc;
    reg               seen;
    integer           fail_count = 0, checks_done = 0, cycles = 0, exp_cause = 0, k, n;
    integer           kinds[$];
    always #20 i_clock = ~i_clock;
    srctl_top #(.NPER(NPER)) dut (.i_clock, .i_sys_rst, .i_ext_rst_n, .i_por_active,
        .i_supply_bad, .i_wdt_second_timeout, .i_wdt_reset_en, .i_test_mode_pin_0,
        .i_test_mode_pin_1, .i_fetch_ack, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_core_rst,
        .o_debug_rst, .o_periph_rst, .o_brownout_irq, .o_fetch_kind, .o_fetch_req, .o_running);
    srctl_fetch_model fetch (.i_clock, .i_slow(slow), .i_fetch_req(o_fetch_req),
        .o_fetch_ack(i_fetch_ack), .o_test_mode_pin_0(i_test_mode_pin_0),
        .o_test_mode_pin_1(i_test_mode_pin_1));
    // ------------------------------------
    // Bus, compare and report tasks
    // ------------------------------------
    function [31:0] rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    task results;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // Hang guard: whole run is a few hundred cycles
    always @(posedge i_clock) begin
        cycles = cycles + 1;
        if (i_fetch_ack === 1'b1 && o_fetch_req === 1'b1)
            kinds.push_back(o_fetch_kind);
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            results;
        end
    end
    task check(input string nm, input [95:0] s, input [95:0] e);
        begin
            checks_done = checks_done + 1;
            if (s !== e) begin
                fail_count = fail_count + 1;
                $display("FAIL %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task axi_wr(input [7:0] a, input [31:0] d);
        reg done;
        begin
            done = 1'b0;
            @(posedge i_clock);
            i_awaddr <= a;
            i_wdata <= d;
            i_awvalid <= 1'b1;
            i_wvalid <= 1'b1;
            i_bready <= 1'b1;
            while (!done) begin
                @(posedge i_clock);
                if (o_awready) i_awvalid <= 1'b0;
                if (o_wready) i_wvalid <= 1'b0;
                if (o_bvalid) begin
                    wr_resp = o_bresp;
                    i_bready <= 1'b0;
                    done = 1'b1;
                end
            end
        end
    endtask
    task axi_rd(input [7:0] a);
        reg done;
        begin
            done = 1'b0;
            @(posedge i_clock);
            i_araddr <= a;
            i_arvalid <= 1'b1;
            i_rready <= 1'b1;
            while (!done) begin
                @(posedge i_clock);
                if (o_arready) i_arvalid <= 1'b0;
                if (o_rvalid) begin
                    rd_data = o_rdata;
                    rd_resp = o_rresp;
                    i_rready <= 1'b0;
                    done = 1'b1;
                end
            end
        end
    endtask
    task rd_chk(input [7:0] a, input [31:0] e, input string nm);
        begin
            axi_rd(a);
            check(nm, rd_data, e);
        end
    endtask
    task wait_boot;
        begin
            while (o_core_rst !== 1'b0 || o_running !== 1'b1) @(posedge i_clock);
            check("fetch count", kinds.size(), 3);
            for (k = 0; k < kinds.size(); k = k + 1)
                check("fetch kind", kinds[k], k);
            kinds.delete();
        end
    endtask
    // ------------------------------------
    // Scenarios
    // ------------------------------------
    initial begin
        repeat (5) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        i_por_active <= 1'b1;
        repeat (6) @(posedge i_clock);
        check("debug reset", o_debug_rst, 1);
        check("core reset", o_core_rst, 1);
        check("periph reset", &o_periph_rst, 1);
        i_por_active <= 1'b0;
        wait_boot;
        exp_cause = 1 << `SRCTL_CAUSE_POR;
        rd_chk(`SRCTL_OFS_CAUSE, exp_cause, "cause");
        rd_chk(`SRCTL_OFS_STATUS, 32'h2, "status");
        i_por_active <= 1'b1;
        repeat (4) @(posedge i_clock);
        check("core reset", o_core_rst, 0);
        i_por_active <= 1'b0;
        rd_chk(8'h1c, 32'h0, "unmapped data");
        check("unmapped resp", rd_resp, `SRCTL_RESP_SLVERR);
        axi_wr(8'h1c, 32'h0);
        check("unmapped bresp", wr_resp, `SRCTL_RESP_SLVERR);
        $display("test power-on done");
        slow <= rnd() % 2;
        rd_chk(`SRCTL_OFS_BROWNOUT, `SRCTL_BROWNOUT_RST, "brown-out ctrl");
        i_supply_bad <= 1'b1;
        repeat (4) @(posedge i_clock);
        check("brown-out irq", o_brownout_irq, 1);
        check("core reset", o_core_rst, 0);
        i_supply_bad <= 1'b0;
        axi_wr(`SRCTL_OFS_BROWNOUT, 1 << `SRCTL_BO_INT_CLR);
        repeat (2) @(posedge i_clock);
        check("brown-out irq", o_brownout_irq, 0);
        axi_wr(`SRCTL_OFS_BROWNOUT, 1 << `SRCTL_BO_RESET_EN);
        i_supply_bad <= 1'b1;
        repeat (20) @(posedge i_clock);
        check("core reset", o_core_rst, 1);
        check("debug reset", o_debug_rst, 0);
        i_supply_bad <= 1'b0;
        wait_boot;
        exp_cause = exp_cause | (1 << `SRCTL_CAUSE_BOR);
        rd_chk(`SRCTL_OFS_CAUSE, exp_cause, "cause");
        $display("test brown-out done");
        for (n = 0; n < 2; n = n + 1) begin
            i_wdt_reset_en <= n[0];
            i_wdt_second_timeout <= 1'b1;
            @(posedge i_clock);
            i_wdt_second_timeout <= 1'b0;
            repeat (2) @(posedge i_clock);
            check("core reset", o_core_rst, n);
        end
        wait_boot;
        exp_cause = exp_cause | (1 << `SRCTL_CAUSE_WDT);
        rd_chk(`SRCTL_OFS_CAUSE, exp_cause, "cause");
        axi_wr(`SRCTL_OFS_APPINT, 1 << `SRCTL_APPINT_SYSREQ);
        seen = 1'b0;
        repeat (4) begin
            @(posedge i_clock);
            seen = seen | (o_core_rst === 1'b1);
        end
        check("core reset", seen, 1);
        check("debug reset", o_debug_rst, 0);
        wait_boot;
        exp_cause = exp_cause | (1 << `SRCTL_CAUSE_SW);
        rd_chk(`SRCTL_OFS_CAUSE, exp_cause, "cause");
        $display("test watchdog and system request done");
        i_ext_rst_n <= 1'b0;
        repeat (5) @(posedge i_clock);
        check("core reset", o_core_rst, 1);
        check("debug reset", o_debug_rst, 0);
        i_ext_rst_n <= 1'b1;
        wait_boot;
        exp_cause = 1 << `SRCTL_CAUSE_EXT;
        rd_chk(`SRCTL_OFS_CAUSE, exp_cause, "cause");
        for (n = 0; n < 3; n = n + 1) begin
            k = rnd() % NPER;
            axi_wr(`SRCTL_OFS_PRST0 + 4 * n, 1 << k);
            acc = 0;
            axi_wr(`SRCTL_OFS_PRST0 + 4 * n, 0);
            repeat (4) begin
                @(posedge i_clock);
                acc = acc | o_periph_rst;
            end
            check("periph reset", acc, 96'h1 << (n * NPER + k));
            check("core reset", o_core_rst, 0);
        end
        $display("test pin and peripheral done");
        results;
    end
endmodule // tb
